// file: common/custom_judgment_pkg.sv
/*
  Package of the custom judgment output block: register offsets, field
  positions, codes and reset values.
  Assumes a 32-bit AHB-Lite bus with word-aligned registers.
*/
`default_nettype none

package custom_judgment_pkg;

  localparam int unsigned PIN_COUNT = 2;
  localparam int unsigned SRC_COUNT = 13;

  localparam logic [7:0] PIN1_CFG_ADDR = 8'h00;
  localparam logic [7:0] PIN2_CFG_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;

  localparam int unsigned POL_LSB = 0;
  localparam int unsigned OPA_LSB = 4;
  localparam int unsigned OPB_LSB = 8;
  localparam int unsigned OP_LSB = 12;
  localparam int unsigned ST_PIN_LSB = 0;
  localparam int unsigned ST_SRC_LSB = 8;

  localparam logic [1:0] POL_ACTIVE_LOW = 2'h1;
  localparam logic [1:0] POL_ACTIVE_HIGH = 2'h2;

  localparam logic [3:0] SRC_BIN1 = 4'h1;
  localparam logic [3:0] SRC_BIN8 = 4'h8;
  localparam logic [3:0] SRC_BIN_OUT = 4'h9;
  localparam logic [3:0] SRC_HIGH = 4'hA;
  localparam logic [3:0] SRC_LOW = 4'hB;
  localparam logic [3:0] SRC_PASS = 4'hC;
  localparam logic [3:0] SRC_FAIL = 4'hD;

  localparam logic [1:0] OP_FIRST_ONLY = 2'h1;
  localparam logic [1:0] OP_AND = 2'h2;
  localparam logic [1:0] OP_OR = 2'h3;

  localparam logic [1:0] POL_RESET = 2'h2;
  localparam logic [3:0] OPA_RESET = 4'hC;
  localparam logic [3:0] OPB_RESET = 4'hD;
  localparam logic [1:0] OP_RESET = 2'h1;

  typedef struct packed {
    logic [1:0] pol;
    logic [3:0] opa;
    logic [3:0] opb;
    logic [1:0] op;
  } pin_cfg_t;

endpackage

`default_nettype wire

// file: rtl/custom_judgment_output.sv
/*
  Two configurable handler output pins driven from judgment results, with
  their settings held in registers reached over AHB-Lite.
  Assumes the judgment inputs come from logic on hclk and the slave is the
  only one on its bus, so hreadyout is also the bus hready.
*/
// Functional notes
// - Polarity code 1 drives the pin active low, code 2 active high.
// - First operand codes: 1-8 bins, 9 bin-out, 10 high, 11 low, 12 pass, 13 fail.
// - Operator code 1 first operand alone, 2 AND, 3 OR.
// - With operator code 1 the second operand is ignored.
// - Second operand uses the same source coding as the first.
// - Every setting reads back as the last legal code written; a word with any illegal field is refused.
`default_nettype none

module custom_judgment_output
  import custom_judgment_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] bin_judge,
  input wire logic bin_out_judge,
  input wire logic high_judge,
  input wire logic low_judge,
  input wire logic pass_judge,
  input wire logic fail_judge,
  output logic pin1_out,
  output logic pin2_out
);

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    pin_cfg_t [PIN_COUNT-1:0] cfg;
    logic [31:0] rdata;
    logic [PIN_COUNT-1:0] pin;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [SRC_COUNT-1:0] srcs;
  logic addr_phase;

  function automatic logic src_valid(input logic [3:0] code);
    src_valid = (code >= SRC_BIN1) && (code <= SRC_FAIL);
  endfunction

  // Code n selects source bit n-1; an unknown code selects a constant low.
  function automatic logic pick(input logic [3:0] code, input logic [SRC_COUNT-1:0] v);
    logic [3:0] idx;
    idx = code - 4'h1;
    pick = src_valid(code) ? v[idx] : 1'b0;
  endfunction

  function automatic logic cfg_valid(input pin_cfg_t c);
    cfg_valid = (c.pol == POL_ACTIVE_LOW || c.pol == POL_ACTIVE_HIGH) && src_valid(c.opa) &&
      src_valid(c.opb) && (c.op != 2'h0);
  endfunction

  function automatic logic condition(input pin_cfg_t c, input logic [SRC_COUNT-1:0] v);
    logic a;
    logic b;
    a = pick(c.opa, v);
    b = pick(c.opb, v);
    case (c.op)
      OP_AND: condition = a & b;
      OP_OR: condition = a | b;
      default: condition = a;
    endcase
  endfunction

  function automatic logic pin_level(input pin_cfg_t c, input logic [SRC_COUNT-1:0] v);
    pin_level = (c.pol == POL_ACTIVE_LOW) ? ~condition(c, v) : condition(c, v);
  endfunction

  function automatic pin_cfg_t unpack_cfg(input logic [31:0] w);
    pin_cfg_t c;
    c.pol = w[POL_LSB +: 2];
    c.opa = w[OPA_LSB +: 4];
    c.opb = w[OPB_LSB +: 4];
    c.op = w[OP_LSB +: 2];
    unpack_cfg = c;
  endfunction

  function automatic logic [31:0] pack_cfg(input pin_cfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[POL_LSB +: 2] = c.pol;
    w[OPA_LSB +: 4] = c.opa;
    w[OPB_LSB +: 4] = c.opb;
    w[OP_LSB +: 2] = c.op;
    pack_cfg = w;
  endfunction

  function automatic logic [7:0] cfg_addr(input int unsigned i);
    cfg_addr = (i == 0) ? PIN1_CFG_ADDR : PIN2_CFG_ADDR;
  endfunction

  assign srcs = {fail_judge, pass_judge, low_judge, high_judge, bin_out_judge, bin_judge};
  assign addr_phase = hsel && htrans[1] && hready;

  always_comb begin
    s_d = s_q;
    // Data phase of a write: take the word only if every field is a legal code.
    if (s_q.wr_pend) begin
      for (int unsigned i = 0; i < PIN_COUNT; i++) begin
        if (s_q.wr_addr == cfg_addr(i) && cfg_valid(unpack_cfg(hwdata))) begin
          s_d.cfg[i] = unpack_cfg(hwdata);
        end
      end
    end
    s_d.wr_pend = 1'b0;
    if (addr_phase && hwrite) begin
      s_d.wr_pend = 1'b1;
      s_d.wr_addr = haddr[7:0];
    end
    // Read data is built from the next state so a read right after a write sees it.
    if (addr_phase && !hwrite) begin
      s_d.rdata = 32'h0000_0000;
      for (int unsigned i = 0; i < PIN_COUNT; i++) begin
        if (haddr[7:0] == cfg_addr(i)) begin
          s_d.rdata = pack_cfg(s_d.cfg[i]);
        end
      end
      if (haddr[7:0] == STATUS_ADDR) begin
        s_d.rdata[ST_PIN_LSB +: PIN_COUNT] = s_q.pin;
        s_d.rdata[ST_SRC_LSB +: SRC_COUNT] = srcs;
      end
    end
    for (int unsigned i = 0; i < PIN_COUNT; i++) begin
      s_d.pin[i] = pin_level(s_q.cfg[i], srcs);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q.wr_pend <= 1'b0;
      s_q.wr_addr <= 8'h00;
      s_q.rdata <= 32'h0000_0000;
      s_q.pin <= '0;
      for (int unsigned i = 0; i < PIN_COUNT; i++) begin
        s_q.cfg[i] <= '{pol: POL_RESET, opa: OPA_RESET, opb: OPB_RESET, op: OP_RESET};
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign pin1_out = s_q.pin[0];
  assign pin2_out = s_q.pin[1];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  pin_follow_a: assert property (##1 pin1_out == pin_level($past(s_q.cfg[0]), $past(srcs)))
    else $error("pin1 level does not follow its judgment and configuration");

  pol_low_a: assert property ((s_q.cfg[1].pol == POL_ACTIVE_LOW && condition(s_q.cfg[1], srcs))
    |=> !pin2_out)
    else $error("active low pin2 not low while its condition is true");

  pol_high_a: assert property ((s_q.cfg[0].pol == POL_ACTIVE_HIGH && !condition(s_q.cfg[0], srcs))
    |=> !pin1_out)
    else $error("active high pin1 not low while its condition is false");

  first_only_a: assert property ((s_q.cfg[0].op == OP_FIRST_ONLY && s_q.cfg[0].pol == POL_ACTIVE_HIGH &&
    s_q.cfg[0].opa == SRC_HIGH) |=> pin1_out == $past(high_judge))
    else $error("first operand alone does not decide pin1");

  and_op_a: assert property ((s_q.cfg[1].op == OP_AND && s_q.cfg[1].pol == POL_ACTIVE_HIGH &&
    s_q.cfg[1].opa == SRC_PASS && s_q.cfg[1].opb == SRC_FAIL && pass_judge && !fail_judge)
    |=> !pin2_out)
    else $error("AND of pass and fail drove pin2 true");

  or_op_a: assert property ((s_q.cfg[0].op == OP_OR && s_q.cfg[0].pol == POL_ACTIVE_HIGH &&
    s_q.cfg[0].opa == SRC_BIN1 && s_q.cfg[0].opb == SRC_LOW && !bin_judge[0] && low_judge)
    |=> pin1_out)
    else $error("OR with true second operand left pin1 low");

  bin_pick_a: assert property ((s_q.cfg[1].op == OP_FIRST_ONLY && s_q.cfg[1].pol == POL_ACTIVE_LOW &&
    s_q.cfg[1].opa == SRC_BIN8) |=> pin2_out == !$past(bin_judge[7]))
    else $error("bin8 source not routed to pin2");

  write_take_a: assert property ((s_q.wr_pend && s_q.wr_addr == PIN2_CFG_ADDR && cfg_valid(unpack_cfg(hwdata)))
    |=> (s_q.cfg[1] == unpack_cfg($past(hwdata)) && $stable(s_q.cfg[0])))
    else $error("pin2 write not stored or leaked into pin1");

  readback_a: assert property ((addr_phase && !hwrite && haddr[7:0] == PIN1_CFG_ADDR && !s_q.wr_pend)
    |=> hrdata == pack_cfg(s_q.cfg[0]))
    else $error("pin1 configuration readback differs from stored code");

  // The second pin is held to the same registered law as the first.
  pin2_follow_a: assert property (##1 pin2_out == pin_level($past(s_q.cfg[1]), $past(srcs)))
    else $error("pin2 level does not follow its judgment and configuration");

  // The slave never stalls and never reports an error.
  bus_answer_a: assert property (hreadyout && !hresp)
    else $error("slave inserted a wait state or an error response");

  // A word with an illegal field leaves both pins' settings untouched.
  refuse_bad_a: assert property ((s_q.wr_pend && !cfg_valid(unpack_cfg(hwdata))) |=> $stable(s_q.cfg))
    else $error("illegal configuration word was stored");

  pin1_write_a: assert property ((s_q.wr_pend && s_q.wr_addr == PIN1_CFG_ADDR && cfg_valid(unpack_cfg(hwdata)))
    |=> (s_q.cfg[0] == unpack_cfg($past(hwdata)) && $stable(s_q.cfg[1])))
    else $error("pin1 write not stored or leaked into pin2");

  status_ro_a: assert property ((s_q.wr_pend && s_q.wr_addr == STATUS_ADDR) |=> $stable(s_q.cfg))
    else $error("write to the status word changed a configuration");

  readback2_a: assert property ((addr_phase && !hwrite && haddr[7:0] == PIN2_CFG_ADDR && !s_q.wr_pend)
    |=> hrdata == pack_cfg(s_q.cfg[1]))
    else $error("pin2 configuration readback differs from stored code");

  unmapped_read_a: assert property ((addr_phase && !hwrite && haddr[7:0] != PIN1_CFG_ADDR &&
    haddr[7:0] != PIN2_CFG_ADDR && haddr[7:0] != STATUS_ADDR) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read returned a nonzero word");

  unused_bits_a: assert property ((addr_phase && !hwrite && haddr[7:0] == PIN1_CFG_ADDR)
    |=> (hrdata[31:14] == 18'h0_0000 && hrdata[3:2] == 2'h0))
    else $error("unused configuration bits read back nonzero");

  status_read_a: assert property ((addr_phase && !hwrite && haddr[7:0] == STATUS_ADDR)
    |=> (hrdata[ST_PIN_LSB +: PIN_COUNT] == $past(s_q.pin) && hrdata[ST_SRC_LSB +: SRC_COUNT] == $past(srcs)))
    else $error("status word does not show pins and sources");

  // Read data stands until the next read is taken.
  rdata_hold_a: assert property (!(addr_phase && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  cfg_legal_a: assert property (cfg_valid(s_q.cfg[0]) && cfg_valid(s_q.cfg[1]))
    else $error("a stored configuration holds an illegal code");

  pol_low1_a: assert property ((s_q.cfg[0].pol == POL_ACTIVE_LOW && condition(s_q.cfg[0], srcs))
    |=> !pin1_out)
    else $error("active low pin1 not low while its condition is true");

  pol_high2_a: assert property ((s_q.cfg[1].pol == POL_ACTIVE_HIGH && !condition(s_q.cfg[1], srcs))
    |=> !pin2_out)
    else $error("active high pin2 not low while its condition is false");

  pol_high_true_a: assert property ((s_q.cfg[0].pol == POL_ACTIVE_HIGH && condition(s_q.cfg[0], srcs))
    |=> pin1_out)
    else $error("active high pin1 not high while its condition is true");

  pol_low_false_a: assert property ((s_q.cfg[1].pol == POL_ACTIVE_LOW && !condition(s_q.cfg[1], srcs))
    |=> pin2_out)
    else $error("active low pin2 not high while its condition is false");

  // With the operator off, the second operand has no say at all.
  opb_ignored_a: assert property ((s_q.cfg[1].op == OP_FIRST_ONLY && s_q.cfg[1].pol == POL_ACTIVE_HIGH &&
    s_q.cfg[1].opa == SRC_PASS) |=> pin2_out == $past(pass_judge))
    else $error("second operand influenced pin2 with the operator off");

  bin_out_pick_a: assert property ((s_q.cfg[0].op == OP_FIRST_ONLY && s_q.cfg[0].pol == POL_ACTIVE_HIGH &&
    s_q.cfg[0].opa == SRC_BIN_OUT) |=> pin1_out == $past(bin_out_judge))
    else $error("bin-out source not routed to pin1");

  low_pick_a: assert property ((s_q.cfg[0].op == OP_FIRST_ONLY && s_q.cfg[0].pol == POL_ACTIVE_HIGH &&
    s_q.cfg[0].opa == SRC_LOW) |=> pin1_out == $past(low_judge))
    else $error("low source not routed to pin1");

  fail_pick_a: assert property ((s_q.cfg[0].op == OP_FIRST_ONLY && s_q.cfg[0].pol == POL_ACTIVE_HIGH &&
    s_q.cfg[0].opa == SRC_FAIL) |=> pin1_out == $past(fail_judge))
    else $error("fail source not routed to pin1");

  opb_and_a: assert property ((s_q.cfg[1].op == OP_AND && s_q.cfg[1].pol == POL_ACTIVE_LOW &&
    s_q.cfg[1].opa == SRC_PASS && s_q.cfg[1].opb == SRC_BIN1)
    |=> pin2_out == !$past(pass_judge && bin_judge[0]))
    else $error("bin1 as second operand not combined into pin2");

endmodule // custom_judgment_output

`default_nettype wire

// file: tb/handler_model.sv
/*
  Model of the handler equipment that reads the two custom output pins.
  Assumes the pins are levels that the handler samples on the block's clock.
*/
`default_nettype none
module handler_model (
  input wire logic hclk,
  input wire logic pin1_out,
  input wire logic pin2_out,
  output logic seen1,
  output logic seen2
);
  timeunit 1ns;
  timeprecision 1ps;
  // The handler latches both pins once a cycle, as equipment strobing its inputs would.
  always_ff @(posedge hclk) begin
    seen1 <= pin1_out;
    seen2 <= pin2_out;
  end
endmodule // handler_model
`default_nettype wire

// file: tb/custom_judgment_output_tb.sv
/*
  Self-checking bench of the custom judgment output block.
  Assumes the block is the only slave on its AHB-Lite bus.
*/
`default_nettype none
module custom_judgment_output_tb
  import custom_judgment_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [12:0] src = 13'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, pin1_out, pin2_out, seen1, seen2;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #5 hclk = ~hclk;
  custom_judgment_output custom_judgment_output_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .bin_judge(src[7:0]), .bin_out_judge(src[8]), .high_judge(src[9]),
    .low_judge(src[10]), .pass_judge(src[11]), .fail_judge(src[12]), .pin1_out(pin1_out), .pin2_out(pin2_out));
  handler_model handler_model_i (.hclk(hclk), .pin1_out(pin1_out), .pin2_out(pin2_out), .seen1(seen1),
    .seen2(seen2));
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  function automatic logic [31:0] cw(input logic [1:0] p, input logic [3:0] a, input logic [3:0] b,
    input logic [1:0] o);
    return {18'h0, o, b, a, 2'h0, p};
  endfunction
  function automatic logic [12:0] oh(input int k);
    return 13'h1 << (k - 1);
  endfunction
  // Pins are registered and the handler samples them again, so three edges suffice.
  task automatic drive(input logic [12:0] s, input logic e1, input logic e2);
    src <= s;
    repeat (3) @(posedge hclk);
    chk({30'h0, seen2, seen1}, {30'h0, e2, e1});
  endtask
  task automatic test_reset();
    xfer(1'b0, PIN1_CFG_ADDR, 32'h0);
    chk(rd, cw(POL_RESET, OPA_RESET, OPB_RESET, OP_RESET));
    drive(oh(12), 1'b1, 1'b1);
    drive(oh(13), 1'b0, 1'b0);
    $display("test reset done");
  endtask
  task automatic test_operands();
    for (int k = 1; k <= 13; k++) begin
      xfer(1'b1, PIN1_CFG_ADDR, cw(POL_ACTIVE_HIGH, 4'(k), SRC_FAIL, OP_FIRST_ONLY));
      xfer(1'b1, PIN2_CFG_ADDR, cw(POL_ACTIVE_LOW, SRC_PASS, 4'(k), OP_AND));
      xfer(1'b0, PIN1_CFG_ADDR, 32'h0);
      chk(rd, cw(POL_ACTIVE_HIGH, 4'(k), SRC_FAIL, OP_FIRST_ONLY));
      xfer(1'b0, PIN2_CFG_ADDR, 32'h0);
      chk(rd, cw(POL_ACTIVE_LOW, SRC_PASS, 4'(k), OP_AND));
      drive(oh(k), 1'b1, k != 12);
      drive(~oh(k), 1'b0, 1'b1);
      drive(oh(k) | oh(12), 1'b1, 1'b0);
    end
    $display("test operands done");
  endtask
  task automatic test_or_refused();
    xfer(1'b1, PIN1_CFG_ADDR, cw(POL_ACTIVE_HIGH, SRC_BIN1, 4'h2, OP_OR));
    drive(oh(2), 1'b1, 1'b1);
    drive(13'h0, 1'b0, 1'b1);
    xfer(1'b1, PIN1_CFG_ADDR, cw(POL_ACTIVE_HIGH, SRC_BIN1, 4'h2, 2'h0));
    xfer(1'b0, PIN1_CFG_ADDR, 32'h0);
    chk(rd, cw(POL_ACTIVE_HIGH, SRC_BIN1, 4'h2, OP_OR));
    drive(oh(1), 1'b1, 1'b1);
    xfer(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    $display("test operator and refusal done");
  endtask
  task automatic test_combine();
    xfer(1'b1, PIN2_CFG_ADDR, cw(POL_ACTIVE_HIGH, SRC_PASS, SRC_FAIL, OP_AND));
    xfer(1'b1, PIN1_CFG_ADDR, cw(POL_ACTIVE_HIGH, SRC_BIN1, SRC_LOW, OP_OR));
    drive(oh(12) | oh(11), 1'b1, 1'b0);
    drive(oh(12) | oh(13), 1'b0, 1'b1);
    xfer(1'b1, PIN2_CFG_ADDR, cw(POL_ACTIVE_LOW, SRC_BIN8, SRC_PASS, OP_FIRST_ONLY));
    drive(oh(8), 1'b0, 1'b0);
    xfer(1'b0, STATUS_ADDR, 32'h0);
    chk(rd, {11'h0, oh(8), 8'h0});
    xfer(1'b1, STATUS_ADDR, cw(POL_ACTIVE_HIGH, SRC_PASS, SRC_PASS, OP_OR));
    xfer(1'b0, PIN2_CFG_ADDR, 32'h0);
    chk(rd, cw(POL_ACTIVE_LOW, SRC_BIN8, SRC_PASS, OP_FIRST_ONLY));
    drive(13'h0, 1'b0, 1'b1);
    $display("test combine done");
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_operands();
    test_or_refused();
    test_combine();
    conclude();
  end
endmodule // custom_judgment_output_tb
`default_nettype wire
